// *** rtl/ibc_pkg.sv ***
// package: register map and field layout of the bus control logic
//
// Operation
// - disable bit set at reset holds the bus engine reset; registers stay accessible
// - status flags carry no meaning while the module is disabled
// - all other control fields have no effect until disable is cleared
// - slave logic waits for the next detected START after enabling
// - master start after enabling mid-byte may corrupt; arbitration settles it
// - interrupt request only when irq enable and bus interrupt flag set
// - clearing irq enable only masks; pending flag stays untouched
// - master select 0 to 1 generates START and enters master mode
// - master select 1 to 0 generates STOP and returns to slave mode
// - arbitration loss clears master select without any STOP
// - direction select: 1 transmit, 0 receive, master and slave
// - receiver drives ack disable value on SDA in data ack slot
// - own address match always acknowledged while enabled and armed by a detected START
// - ack disable used only as receiver, ignored when transmitting
// - writing 1 to repeat start makes repeated START as master; reads 0
// - repeated start while another master owns the bus loses arbitration
// - dma enable drives tx/rx requests when data register needs service
// - dma enabled suppresses byte-complete interrupts, keeps others
// - dma valid only in master mode; no dma for slave transfers
`default_nettype none
package ibc_pkg;

    ////////////////////////////////////////////////////////////////////////
    localparam logic [7:0] BUS_CONTROL_OFS = 8'h00;
    localparam logic [7:0] BUS_STATUS_OFS  = 8'h04;

    localparam int BIT_DISABLE   = 7;
    localparam int BIT_IRQ_EN    = 6;
    localparam int BIT_MASTER    = 5;
    localparam int BIT_DIRECTION = 4;
    localparam int BIT_ACK_DIS   = 3;
    localparam int BIT_RSTART    = 2;
    localparam int BIT_DMA_EN    = 1;

    localparam logic [7:0] BUS_CONTROL_RESET = 8'h80;

    localparam int ST_IRQ_FLAG  = 0;
    localparam int ST_BUSY      = 1;
    localparam int ST_SLAVE_RW  = 2;
    localparam int ST_ARMED     = 3;
    localparam int ST_MASTER    = 4;
    localparam int ST_RS_LOST   = 5;

endpackage
`default_nettype wire

// *** rtl/ibc_ack_drive.sv ***
// acknowledge slot driver for the open-drain data line
`timescale 1ns/100ps
`default_nettype none
module ibc_ack_drive (
    input  wire logic core_clk,
    input  wire logic reset,
    input  wire logic enabled,
    input  wire logic ackSlot,
    input  wire logic addrPhase,
    input  wire logic addrMatch,
    input  wire logic slaveArmed,
    input  wire logic receiver,
    input  wire logic ackDisable,
    output var  logic sdaOut,
    output var  logic sdaOe_n
);

    logic driveLow_nxt;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        driveLow_nxt = 1'b0;
        if (enabled && ackSlot) begin
            if (addrPhase) begin
                driveLow_nxt = addrMatch && slaveArmed;
            end else if (receiver) begin
                driveLow_nxt = !ackDisable;
            end
        end
    end

    // registered so the pin never glitches on decode
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            sdaOut  <= 1'b1;
            sdaOe_n <= 1'b1;
        end else begin
            sdaOut  <= !driveLow_nxt;
            sdaOe_n <= !driveLow_nxt;
        end
    end

    a_ack_released: assert property (@(posedge core_clk) disable iff (reset)
        !enabled |=> sdaOe_n)
        else $error("ack driven while disabled");

    a_addr_acked: assert property (@(posedge core_clk) disable iff (reset)
        enabled && ackSlot && addrPhase && addrMatch && slaveArmed |=> !sdaOe_n && !sdaOut)
        else $error("address match not acknowledged");

endmodule // ibc_ack_drive
`default_nettype wire

// *** rtl/ibc_bus_control.sv ***
// bus control register, mode sequencing and apb slave
//
// The address map and the APB slave port were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module ibc_bus_control (
    input  wire logic        core_clk,
    input  wire logic        reset,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr,
    // status side
    input  wire logic        busIrqFlag,
    input  wire logic        busBusy,
    input  wire logic        startDetect,
    input  wire logic        arbLost,
    input  wire logic        slaveRwFlag,
    input  wire logic        dataNeedWrite,
    input  wire logic        dataNeedRead,
    // acknowledge slot info
    input  wire logic        ackSlot,
    input  wire logic        addrPhase,
    input  wire logic        addrMatch,
    // bus engine commands
    output var  logic        engineReset,
    output var  logic        startPulse,
    output var  logic        stopPulse,
    output var  logic        rstartPulse,
    output var  logic        rstartLost,
    output var  logic        masterMode,
    output var  logic        transmitMode,
    output var  logic        slaveArmed,
    output var  logic        byteIrqSuppress,
    output var  logic        irqReq,
    output var  logic        dmaTxReq,
    output var  logic        dmaRxReq,
    // open-drain data line
    output var  logic        sdaOut,
    output var  logic        sdaOe_n
);

    logic [7:0] control_r;
    logic       master_r;
    logic       armed_r;
    logic       rsLost_r;
    logic       enabled;
    logic       wrCycle;
    logic       rdCycle;
    logic       ctrlWrite;
    logic [7:0] wrByte;
    logic       master_nxt;
    logic       hitCtrl;
    logic       hitStatus;

    function automatic logic fieldOf(input logic [7:0] v, input int pos);
        return v[pos];
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // apb decode, zero wait state
    assign pready  = 1'b1;
    assign wrCycle = psel && penable && pwrite;
    assign rdCycle = psel && penable && !pwrite;
    assign wrByte  = pwdata[7:0];

    always_comb begin
        hitCtrl   = 1'b0;
        hitStatus = 1'b0;
        if (paddr == ibc_pkg::BUS_CONTROL_OFS) begin
            hitCtrl = 1'b1;
        end else if (paddr == ibc_pkg::BUS_STATUS_OFS) begin
            hitStatus = 1'b1;
        end
    end

    assign pslverr   = psel && penable && !(hitCtrl || (hitStatus && !pwrite));
    assign ctrlWrite = wrCycle && hitCtrl;

    ////////////////////////////////////////////////////////////////////////
    // disable holds engine reset
    assign enabled     = !fieldOf(control_r, ibc_pkg::BIT_DISABLE);
    assign engineReset = !enabled;

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            control_r <= ibc_pkg::BUS_CONTROL_RESET;
        end else if (ctrlWrite) begin
            control_r <= wrByte;
            control_r[ibc_pkg::BIT_RSTART] <= 1'b0;
            control_r[ibc_pkg::BIT_MASTER] <= master_nxt;
        end else begin
            control_r[ibc_pkg::BIT_MASTER] <= master_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // master state follows the register; arbitration loss overrides
    always_comb begin
        master_nxt = control_r[ibc_pkg::BIT_MASTER];
        if (ctrlWrite) begin
            master_nxt = wrByte[ibc_pkg::BIT_MASTER];
        end
        if (!enabled) begin
            master_nxt = ctrlWrite ? wrByte[ibc_pkg::BIT_MASTER] : master_nxt;
        end else if (arbLost || rsLost_r) begin
            master_nxt = 1'b0;
        end
    end

    // master_r tracks the mode actually entered on the bus
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            master_r    <= 1'b0;
            startPulse  <= 1'b0;
            stopPulse   <= 1'b0;
        end else begin
            startPulse <= 1'b0;
            stopPulse  <= 1'b0;
            if (!enabled) begin
                master_r <= 1'b0;
            end else if (arbLost) begin
                master_r <= 1'b0;
            end else if (ctrlWrite && wrByte[ibc_pkg::BIT_MASTER] && !master_r) begin
                // start issued blind to a mid-byte bus
                // a disabling write resets the engine, so no mastership is kept
                master_r   <= !wrByte[ibc_pkg::BIT_DISABLE];
                startPulse <= 1'b1;
            end else if (ctrlWrite && !wrByte[ibc_pkg::BIT_MASTER] && master_r) begin
                master_r  <= 1'b0;
                stopPulse <= 1'b1;
            end else if (ctrlWrite && wrByte[ibc_pkg::BIT_DISABLE]) begin
                master_r <= 1'b0;
            end
        end
    end

    assign masterMode = master_r;

    ////////////////////////////////////////////////////////////////////////
    // repeated start handling
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            rstartPulse <= 1'b0;
            rsLost_r    <= 1'b0;
        end else begin
            rstartPulse <= 1'b0;
            rsLost_r    <= 1'b0;
            if (enabled && ctrlWrite && wrByte[ibc_pkg::BIT_RSTART]) begin
                if (master_r) begin
                    rstartPulse <= 1'b1;
                end else if (busBusy) begin
                    rsLost_r <= 1'b1;
                end
            end
        end
    end

    assign rstartLost = rsLost_r;

    ////////////////////////////////////////////////////////////////////////
    // slave arming: a byte already in flight is not ours to decode
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            armed_r <= 1'b0;
        end else if (!enabled) begin
            armed_r <= 1'b0;
        end else if (startDetect) begin
            armed_r <= 1'b1;
        end
    end

    assign slaveArmed = armed_r;

    ////////////////////////////////////////////////////////////////////////
    // direction select
    assign transmitMode = enabled && fieldOf(control_r, ibc_pkg::BIT_DIRECTION);

    assign irqReq = enabled && fieldOf(control_r, ibc_pkg::BIT_IRQ_EN) && busIrqFlag;

    assign byteIrqSuppress = enabled && fieldOf(control_r, ibc_pkg::BIT_DMA_EN);

    // requests registered as data outputs
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            dmaTxReq <= 1'b0;
            dmaRxReq <= 1'b0;
        end else begin
            dmaTxReq <= byteIrqSuppress && master_r && dataNeedWrite;
            dmaRxReq <= byteIrqSuppress && master_r && dataNeedRead;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read data, registered at the end of the setup phase
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= 32'h0000_0000;
            if (paddr == ibc_pkg::BUS_CONTROL_OFS) begin
                prdata[7:0] <= control_r;
            end else if (paddr == ibc_pkg::BUS_STATUS_OFS) begin
                prdata[ibc_pkg::ST_IRQ_FLAG] <= busIrqFlag;
                prdata[ibc_pkg::ST_BUSY]     <= busBusy;
                prdata[ibc_pkg::ST_SLAVE_RW] <= slaveRwFlag;
                prdata[ibc_pkg::ST_ARMED]    <= armed_r;
                prdata[ibc_pkg::ST_MASTER]   <= master_r;
                prdata[ibc_pkg::ST_RS_LOST]  <= rsLost_r;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    ibc_ack_drive u_ack (
        .core_clk   (core_clk),
        .reset      (reset),
        .enabled    (enabled),
        .ackSlot    (ackSlot),
        .addrPhase  (addrPhase),
        .addrMatch  (addrMatch),
        .slaveArmed (armed_r),
        .receiver   (!transmitMode),
        .ackDisable (fieldOf(control_r, ibc_pkg::BIT_ACK_DIS)),
        .sdaOut     (sdaOut),
        .sdaOe_n    (sdaOe_n)
    );

    ////////////////////////////////////////////////////////////////////////
    // checks
    a_disable_reset: assert property (@(posedge core_clk) disable iff (reset)
        control_r[ibc_pkg::BIT_DISABLE] |-> engineReset && !masterMode)
        else $error("engine active while disabled");

    a_disabled_quiet: assert property (@(posedge core_clk) disable iff (reset)
        !enabled |=> !startPulse && !stopPulse && !rstartPulse)
        else $error("command issued while disabled");

    a_irq_gate: assert property (@(posedge core_clk) disable iff (reset)
        irqReq == (enabled && control_r[ibc_pkg::BIT_IRQ_EN] && busIrqFlag))
        else $error("interrupt gating wrong");

    a_start_on_set: assert property (@(posedge core_clk) disable iff (reset)
        enabled && ctrlWrite && wrByte[ibc_pkg::BIT_MASTER] && !master_r && !arbLost
        |=> startPulse ##1 !startPulse)
        else $error("start missing");

    a_stop_on_clear: assert property (@(posedge core_clk) disable iff (reset)
        enabled && ctrlWrite && !wrByte[ibc_pkg::BIT_MASTER] && master_r && !arbLost
        |=> stopPulse && !masterMode)
        else $error("stop missing");

    a_lost_no_stop: assert property (@(posedge core_clk) disable iff (reset)
        enabled && arbLost |=> !stopPulse && !masterMode)
        else $error("stop after arbitration loss");

    a_rstart_reads_zero: assert property (@(posedge core_clk) disable iff (reset)
        !control_r[ibc_pkg::BIT_RSTART])
        else $error("repeat start reads as one");

    a_rstart_foreign: assert property (@(posedge core_clk) disable iff (reset)
        enabled && ctrlWrite && wrByte[ibc_pkg::BIT_RSTART] && !master_r && busBusy
        |=> rstartLost && !rstartPulse ##1 !masterMode)
        else $error("foreign repeat start not lost");

    a_dma_master_only: assert property (@(posedge core_clk) disable iff (reset)
        (dmaTxReq || dmaRxReq) |-> $past(master_r) && $past(byteIrqSuppress))
        else $error("dma request outside master dma mode");

    a_arm_on_start: assert property (@(posedge core_clk) disable iff (reset)
        $rose(enabled) && !startDetect |-> !slaveArmed)
        else $error("slave armed before start");

    a_dir_transmit: assert property (@(posedge core_clk) disable iff (reset)
        ctrlWrite && !wrByte[ibc_pkg::BIT_DISABLE] && wrByte[ibc_pkg::BIT_DIRECTION]
        |=> transmitMode)
        else $error("transmit not selected");

    a_dir_receive: assert property (@(posedge core_clk) disable iff (reset)
        ctrlWrite && !wrByte[ibc_pkg::BIT_DISABLE] && !wrByte[ibc_pkg::BIT_DIRECTION]
        |=> !transmitMode)
        else $error("receive not selected");

    a_irq_masked: assert property (@(posedge core_clk) disable iff (reset)
        !control_r[ibc_pkg::BIT_IRQ_EN] |-> !irqReq)
        else $error("interrupt not masked");

    a_dma_off_idle: assert property (@(posedge core_clk) disable iff (reset)
        !control_r[ibc_pkg::BIT_DMA_EN] |=> !dmaTxReq && !dmaRxReq)
        else $error("dma request while dma off");

    a_dma_tx_req: assert property (@(posedge core_clk) disable iff (reset)
        enabled && control_r[ibc_pkg::BIT_DMA_EN] && master_r && dataNeedWrite |=> dmaTxReq)
        else $error("dma transmit request missing");

    a_dma_rx_req: assert property (@(posedge core_clk) disable iff (reset)
        enabled && control_r[ibc_pkg::BIT_DMA_EN] && master_r && dataNeedRead |=> dmaRxReq)
        else $error("dma receive request missing");

    a_disabled_inert: assert property (@(posedge core_clk) disable iff (reset)
        !enabled |-> !transmitMode && !irqReq && !byteIrqSuppress)
        else $error("control field active while disabled");

    a_lost_clears_bit: assert property (@(posedge core_clk) disable iff (reset)
        enabled && arbLost |=> !control_r[ibc_pkg::BIT_MASTER])
        else $error("master bit kept after loss");

    a_rstart_owner: assert property (@(posedge core_clk) disable iff (reset)
        enabled && ctrlWrite && wrByte[ibc_pkg::BIT_RSTART] && master_r |=> rstartPulse)
        else $error("repeated start missing");

    a_ctrl_access: assert property (@(posedge core_clk) disable iff (reset)
        psel && penable && paddr == ibc_pkg::BUS_CONTROL_OFS |-> !pslverr)
        else $error("control register refused");

    a_arm_cleared: assert property (@(posedge core_clk) disable iff (reset)
        !enabled |=> !slaveArmed)
        else $error("slave armed while disabled");

    c_start: cover property (@(posedge core_clk) disable iff (reset) startPulse);
    c_stop: cover property (@(posedge core_clk) disable iff (reset) stopPulse);
    c_rstart: cover property (@(posedge core_clk) disable iff (reset) rstartPulse);
    c_dma_tx: cover property (@(posedge core_clk) disable iff (reset) dmaTxReq);
    c_rs_lost: cover property (@(posedge core_clk) disable iff (reset) rstartLost);

endmodule // ibc_bus_control
`default_nettype wire

// *** tb/ibc_bus_partner.sv ***
// far side of the bus: other masters, pull-up line level, bus busy and arbitration
`timescale 1ns/100ps
`default_nettype none
module ibc_bus_partner (
    input  wire logic core_clk,
    input  wire logic reset,
    input  wire logic startPulse,
    input  wire logic stopPulse,
    input  wire logic rstartPulse,
    input  wire logic sdaOut,
    input  wire logic sdaOe_n,
    input  wire logic extStart,
    input  wire logic extStop,
    output var  logic busBusy,
    output var  logic startDetect,
    output var  logic arbLost,
    output var  logic sdaLine
);
    ////////////////////////////////////////////////////////////////////////
    // pull-up wire level
    // released line reads high, never the last driven value
    assign sdaLine = sdaOe_n ? 1'b1 : sdaOut;

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            busBusy     <= 1'b0;
            startDetect <= 1'b0;
            arbLost     <= 1'b0;
        end else begin
            startDetect <= startPulse | rstartPulse | extStart;
            // start onto busy bus
            // the colliding start corrupts the cycle; the device loses here
            arbLost     <= startPulse & busBusy;
            if (startPulse | extStart) begin
                busBusy <= 1'b1;
            end else if (stopPulse | extStop) begin
                busBusy <= 1'b0;
            end
        end
    end
endmodule // ibc_bus_partner
`default_nettype wire

// *** tb/i2c_bus_control_logic_test.sv ***
// self-checking bench for the bus control register block
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin failures++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, (a), (e)); end end
module i2c_bus_control_logic_test;
    typedef struct packed {
        logic [7:0] d;
        logic       f;
        logic       nw;
        logic       irq;
        logic       tx;
        logic       sup;
        logic [7:0] rb;
    } ibc_row_s;
    logic        core_clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rdat;
    logic        busIrqFlag = 1'b0, slaveRwFlag = 1'b0, dataNeedWrite = 1'b0, dataNeedRead = 1'b0;
    logic        ackSlot = 1'b0, addrPhase = 1'b0, addrMatch = 1'b0, extStart = 1'b0, extStop = 1'b0;
    logic        pready, pslverr, busBusy, startDetect, arbLost, engineReset, startPulse;
    logic        stopPulse, rstartPulse, rstartLost, masterMode, transmitMode, slaveArmed;
    logic        byteIrqSuppress, irqReq, dmaTxReq, dmaRxReq, sdaOut, sdaOe_n, sdaLine, rerr;
    int          failures = 0, comparisons = 0;
    ibc_row_s    rows [8] = '{
        '{8'hc0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 8'hc0}, '{8'h40, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 8'h40},
        '{8'h00, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 8'h00}, '{8'h40, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 8'h40},
        '{8'h40, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 8'h40}, '{8'h10, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 8'h10},
        '{8'h0a, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 8'h0a}, '{8'h05, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 8'h01}};

    ibc_bus_control dut (.core_clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .busIrqFlag, .busBusy, .startDetect, .arbLost, .slaveRwFlag,
        .dataNeedWrite, .dataNeedRead, .ackSlot, .addrPhase, .addrMatch, .engineReset,
        .startPulse, .stopPulse, .rstartPulse, .rstartLost, .masterMode, .transmitMode,
        .slaveArmed, .byteIrqSuppress, .irqReq, .dmaTxReq, .dmaRxReq, .sdaOut, .sdaOe_n);
    ibc_bus_partner far (.core_clk, .reset, .startPulse, .stopPulse, .rstartPulse, .sdaOut,
        .sdaOe_n, .extStart, .extStop, .busBusy, .startDetect, .arbLost, .sdaLine);

    always #50 core_clk = ~core_clk;

    ////////////////////////////////////////////////////////////////////////
    // request held until pready seen high at a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        // only the watchdog ends a wait that never sees pready
        do begin
            @(posedge core_clk);
        end while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] d);
        apb(1'b1, 8'h00, {24'h0, d});
        #1;
    endtask

    task automatic ack(input logic ph, input logic expLine);
        @(posedge core_clk);
        ackSlot <= 1'b1;
        addrPhase <= ph;
        addrMatch <= ph;
        @(posedge core_clk);
        #1;
        `CHK(sdaLine, expLine)
        @(posedge core_clk);
        ackSlot <= 1'b0;
    endtask

    task automatic bus_event(input logic st);
        @(posedge core_clk);
        if (st) extStart <= 1'b1; else extStop <= 1'b1;
        @(posedge core_clk);
        extStart <= 1'b0;
        extStop <= 1'b0;
    endtask

    task close_out;
        $display("comparisons=%0d failures=%0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        #(100 * 4000);
        failures++;
        close_out();
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (6) @(posedge core_clk);
        reset <= 1'b0;
        apb(1'b0, 8'h00, 32'h0);
        `CHK(rdat, 32'h00000080)
        `CHK(engineReset, 1'b1)
        apb(1'b0, 8'h08, 32'h0);
        `CHK(rerr, 1'b1)
        apb(1'b1, 8'h04, 32'hff);
        `CHK(rerr, 1'b1)
        wr(8'ha0);
        `CHK(startPulse, 1'b0)
        apb(1'b0, 8'h00, 32'h0);
        `CHK(rdat, 32'h000000a0)
        `CHK(masterMode, 1'b0)
        foreach (rows[i]) begin
            @(posedge core_clk);
            busIrqFlag <= rows[i].f;
            dataNeedWrite <= rows[i].nw;
            wr(rows[i].d);
            @(posedge core_clk);
            #1;
            `CHK(irqReq, rows[i].irq)
            `CHK(transmitMode, rows[i].tx)
            `CHK(byteIrqSuppress, rows[i].sup)
            `CHK(dmaTxReq, 1'b0)
            `CHK(engineReset, rows[i].d[7])
            apb(1'b0, 8'h00, 32'h0);
            `CHK(rdat, {24'h0, rows[i].rb})
        end
        @(posedge core_clk);
        dataNeedWrite <= 1'b1;
        busIrqFlag <= 1'b0;
        wr(8'h30);
        `CHK(startPulse, 1'b1)
        `CHK(masterMode, 1'b1)
        wr(8'h32);
        @(posedge core_clk);
        #1;
        `CHK(dmaTxReq, 1'b1)
        @(posedge core_clk);
        dataNeedWrite <= 1'b0;
        dataNeedRead <= 1'b1;
        @(posedge core_clk);
        #1;
        `CHK(dmaRxReq, 1'b1)
        wr(8'h30);
        @(posedge core_clk);
        #1;
        `CHK(dmaRxReq, 1'b0)
        @(posedge core_clk);
        dataNeedRead <= 1'b0;
        wr(8'h34);
        `CHK(rstartPulse, 1'b1)
        apb(1'b0, 8'h00, 32'h0);
        `CHK(rdat, 32'h00000030)
        @(posedge core_clk);
        busIrqFlag <= 1'b1;
        wr(8'h10);
        `CHK(stopPulse, 1'b1)
        `CHK(masterMode, 1'b0)
        bus_event(1'b1);
        wr(8'h14);
        `CHK(rstartLost, 1'b1)
        `CHK(rstartPulse, 1'b0)
        wr(8'h30);
        `CHK(startPulse, 1'b1)
        repeat (3) begin
            @(posedge core_clk);
            #1;
            `CHK(stopPulse, 1'b0)
        end
        `CHK(masterMode, 1'b0)
        apb(1'b0, 8'h00, 32'h0);
        `CHK(rdat, 32'h00000010)
        bus_event(1'b0);
        wr(8'h80);
        `CHK(engineReset, 1'b1)
        wr(8'h08);
        `CHK(slaveArmed, 1'b0)
        ack(1'b1, 1'b1);
        bus_event(1'b1);
        @(posedge core_clk);
        #1;
        `CHK(slaveArmed, 1'b1)
        ack(1'b1, 1'b0);
        ack(1'b0, 1'b1);
        wr(8'h00);
        ack(1'b0, 1'b0);
        wr(8'h10);
        ack(1'b0, 1'b1);
        @(posedge core_clk);
        slaveRwFlag <= 1'b1;
        apb(1'b0, 8'h04, 32'h0);
        `CHK(rdat[2], 1'b1)
        `CHK(rdat[3], 1'b1)
        close_out();
    end
endmodule // i2c_bus_control_logic_test
`default_nettype wire
